/* tmw_consts.svh */
// Register map, field positions and reset values of the waveform timer
`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH

// Register byte offsets
`define TMW_OFS_CTRL 8'h00
`define TMW_OFS_COUNT 8'h04
`define TMW_OFS_COMPARE 8'h08
`define TMW_OFS_FLAGS 8'h0C

// Control register fields
`define TMW_CTRL_FORCE 0
`define TMW_CTRL_WAVE_LO 1
`define TMW_CTRL_WAVE_HI 2
`define TMW_CTRL_ACT_LO 3
`define TMW_CTRL_ACT_HI 4
`define TMW_CTRL_SRC_LO 5
`define TMW_CTRL_SRC_HI 7

// Flag register fields
`define TMW_FLAG_WRAP 0
`define TMW_FLAG_MATCH 1
`define TMW_FLAG_OUT 2

// Counter extremes
`define TMW_BOTTOM 8'h00
`define TMW_MAX 8'hFF

// Reset values
`define TMW_RST_CTRL 8'h00
`define TMW_RST_COUNT 8'h00
`define TMW_RST_COMPARE 8'h00
`define TMW_RST_SRC 3'h0

`endif

/* tmw_pkg.sv */
// Types shared by the waveform timer files
package tmw_pkg;

    // Waveform selection codes
    typedef enum logic [1:0] {
        TMW_WAVE_NORMAL = 2'h0,
        TMW_WAVE_FAST = 2'h1,
        TMW_WAVE_CTC = 2'h2,
        TMW_WAVE_FAST_ALT = 2'h3
    } tmw_wave_t;

    // Compare output actions
    typedef enum logic [1:0] {
        TMW_ACT_NONE = 2'h0,
        TMW_ACT_TOGGLE = 2'h1,
        TMW_ACT_CLEAR = 2'h2,
        TMW_ACT_SET = 2'h3
    } tmw_act_t;

endpackage

/* tmw_pin_mux.sv */
// Port pin override between the port latch and the compare output state
`timescale 1ns/10ps

module tmw_pin_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Selection
    input wire logic override,
    input wire logic compare_output,
    // Port side
    input wire logic port_latch,
    input wire logic pin_direction,
    // Pin drive
    output logic pin_out,
    output logic pin_oe
);

    // Pin level: compare state replaces the latch whenever overridden
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= override ? compare_output : port_latch;
        end
    end

    // Direction stays with the port direction bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= pin_direction;
        end
    end

endmodule

/* tmw_timer.sv */
// Eight-bit waveform timer with APB registers and compare output pin override
`timescale 1ns/10ps
`include "tmw_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Nonzero output action routes compare output state to the pin instead of latch.
// - Pin direction stays with the port direction bit even when overridden.
// - Override depends on output action only, never on waveform mode.
// - Output action zero leaves compare output unchanged at matches.
// - New output action first acts at the next compare match.
// - Force strobe applies the action at once, only in non-PWM modes.
// - Normal mode increments always, no clear, wraps 0xFF to 0x00.
// - Normal mode sets wrap flag when count becomes zero; interrupt service clears.
// - Normal mode accepts count writes at any time.
// - Clear-on-match mode clears counter when count equals compare value.
// - Unbuffered compare below count makes counter wrap through 0xFF first.
// - Clear-on-match with action one toggles output on every match.
// - Clear-on-match raises match flag each time the top is reached.
// - Clear-on-match sets wrap flag only on the roll from 0xFF to 0x00.
// - Fast PWM counts single slope from zero to 0xFF and restarts.
// - Fast PWM action two clears on match, sets at bottom; three inverts.
// - Fast PWM clears counter on the tick after max, period 256 ticks.
// - Fast PWM sets wrap flag each time the counter reaches max.
// - Fast PWM compare zero gives one-tick spike; max gives constant level.
// - Compare output state flip-flop is separate from the pin driver.
// - Match sets match flag on next tick; write one or service clears.
// - PWM compare writes are buffered until top; others take effect at once.
// - Count write suppresses compare match in the following tick, even stopped.
// - Tick source zero stops the counter; count stays readable and writable.
module tmw_timer (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Timer tick from the clock select logic
    input wire logic TICK,
    // Interrupt service acknowledges
    input wire logic WRAP_ACK,
    input wire logic MATCH_ACK,
    // Event flags
    output logic WRAP_FLAG,
    output logic MATCH_FLAG,
    // Port pin
    input wire logic PORT_LATCH,
    input wire logic PIN_DIRECTION,
    output logic PIN_OUT,
    output logic PIN_OE,
    // Compare output state
    output logic COMPARE_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [1:0] waveform_select;
    logic [1:0] output_action_select;
    logic [2:0] tick_source_select;
    logic [7:0] count_value;
    logic [7:0] compare_buffer;
    logic [7:0] compare_value;
    logic match_block;
    logic compare_output;
    logic apb_setup_ok;
    logic apb_done;
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic lane0;
    logic wr_ctrl;
    logic wr_count;
    logic wr_compare;
    logic wr_flags;
    logic force_match_strobe;
    logic pwm_mode;
    logic ctc_mode;
    logic timer_tick;
    logic match_now;
    logic at_max;
    logic next_at_max;
    logic [7:0] next_count;
    logic set_wrap;
    logic set_match;
    logic clr_wrap;
    logic clr_match;
    logic [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    // Completed access and its kind
    assign apb_done = PSEL & PENABLE & PREADY;
    assign apb_setup_ok = PSEL & PENABLE & ~PREADY;
    assign wr_en = apb_done & PWRITE & ~PSLVERR;
    assign rd_en = apb_setup_ok & ~PWRITE;
    assign lane0 = PSTRB[0];

    // Address map check
    always_comb begin
        addr_hit = 1'b0;
        case (PADDR)
            `TMW_OFS_CTRL: addr_hit = 1'b1;
            `TMW_OFS_COUNT: addr_hit = 1'b1;
            `TMW_OFS_COMPARE: addr_hit = 1'b1;
            `TMW_OFS_FLAGS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // Per-register write strobes, effective on the completing edge
    assign wr_ctrl = wr_en & lane0 & (PADDR == `TMW_OFS_CTRL);
    assign wr_count = wr_en & lane0 & (PADDR == `TMW_OFS_COUNT);
    assign wr_compare = wr_en & lane0 & (PADDR == `TMW_OFS_COMPARE);
    assign wr_flags = wr_en & lane0 & (PADDR == `TMW_OFS_FLAGS);
    assign force_match_strobe = wr_ctrl & PWDATA[`TMW_CTRL_FORCE];

    // One wait state, then ready for a single cycle
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= apb_setup_ok;
        end
    end

    // Error answer for unmapped addresses
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PSLVERR <= 1'b0;
        end else begin
            PSLVERR <= apb_setup_ok & ~addr_hit;
        end
    end

    // Read data selection; force strobe always reads zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (PADDR)
            `TMW_OFS_CTRL: begin
                next_rdata[`TMW_CTRL_WAVE_HI:`TMW_CTRL_WAVE_LO] = waveform_select;
                next_rdata[`TMW_CTRL_ACT_HI:`TMW_CTRL_ACT_LO] = output_action_select;
                next_rdata[`TMW_CTRL_SRC_HI:`TMW_CTRL_SRC_LO] = tick_source_select;
            end
            `TMW_OFS_COUNT: next_rdata[7:0] = count_value;
            `TMW_OFS_COMPARE: next_rdata[7:0] = compare_buffer;
            `TMW_OFS_FLAGS: begin
                next_rdata[`TMW_FLAG_WRAP] = WRAP_FLAG;
                next_rdata[`TMW_FLAG_MATCH] = MATCH_FLAG;
                next_rdata[`TMW_FLAG_OUT] = compare_output;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded with the ready answer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en) begin
            PRDATA <= next_rdata;
        end else if (apb_done) begin
            PRDATA <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    // Mode, action and tick source fields
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            waveform_select <= 2'h0;
            output_action_select <= 2'h0;
            tick_source_select <= `TMW_RST_SRC;
        end else if (wr_ctrl) begin
            waveform_select <= PWDATA[`TMW_CTRL_WAVE_HI:`TMW_CTRL_WAVE_LO];
            output_action_select <= PWDATA[`TMW_CTRL_ACT_HI:`TMW_CTRL_ACT_LO];
            tick_source_select <= PWDATA[`TMW_CTRL_SRC_HI:`TMW_CTRL_SRC_LO];
        end
    end

    // Mode decode; both odd codes run the single-slope PWM
    assign pwm_mode = waveform_select[0];
    assign ctc_mode = (waveform_select == tmw_pkg::TMW_WAVE_CTC);

    // Tick is gated off when no source is selected
    assign timer_tick = TICK & (tick_source_select != 3'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Compare value and match

    // Buffer written by software, active copy loaded per mode
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            compare_buffer <= `TMW_RST_COMPARE;
        end else if (wr_compare) begin
            compare_buffer <= PWDATA[7:0];
        end
    end

    // Active compare: immediate outside PWM, at top inside PWM
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            compare_value <= `TMW_RST_COMPARE;
        end else if (!pwm_mode) begin
            compare_value <= wr_compare ? PWDATA[7:0] : compare_buffer;
        end else if (timer_tick && at_max) begin
            compare_value <= compare_buffer;
        end
    end

    // Count write blocks the match of the next tick, even while stopped
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            match_block <= 1'b0;
        end else if (wr_count) begin
            match_block <= 1'b1;
        end else if (timer_tick) begin
            match_block <= 1'b0;
        end
    end

    // Comparator and extremes
    assign match_now = (count_value == compare_value) & ~match_block;
    assign at_max = (count_value == `TMW_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    // Next count by mode
    always_comb begin
        next_count = count_value + 8'h01;
        if (ctc_mode && match_now) begin
            next_count = `TMW_BOTTOM;
        end else if (pwm_mode && at_max) begin
            next_count = `TMW_BOTTOM;
        end
    end

    assign next_at_max = (next_count == `TMW_MAX);

    // Count register; software write wins over counting
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            count_value <= `TMW_RST_COUNT;
        end else if (wr_count) begin
            count_value <= PWDATA[7:0];
        end else if (timer_tick) begin
            count_value <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags

    // Overflow flag source per mode
    always_comb begin
        if (pwm_mode) begin
            set_wrap = timer_tick & ~wr_count & next_at_max;
        end else begin
            set_wrap = timer_tick & ~wr_count & at_max;
        end
    end

    // Match flag raised on the tick following an equal count
    assign set_match = timer_tick & match_now;
    assign clr_wrap = WRAP_ACK | (wr_flags & PWDATA[`TMW_FLAG_WRAP]);
    assign clr_match = MATCH_ACK | (wr_flags & PWDATA[`TMW_FLAG_MATCH]);

    // Overflow flag; set beats clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            WRAP_FLAG <= 1'b0;
        end else if (set_wrap) begin
            WRAP_FLAG <= 1'b1;
        end else if (clr_wrap) begin
            WRAP_FLAG <= 1'b0;
        end
    end

    // Match flag; set beats clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            MATCH_FLAG <= 1'b0;
        end else if (set_match) begin
            MATCH_FLAG <= 1'b1;
        end else if (clr_match) begin
            MATCH_FLAG <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waveform generator

    // Compare output state, separate from the pin driver
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            compare_output <= 1'b0;
        end else if (!pwm_mode) begin
            if ((timer_tick && match_now) || force_match_strobe) begin
                unique case (output_action_select)
                    tmw_pkg::TMW_ACT_NONE: compare_output <= compare_output;
                    tmw_pkg::TMW_ACT_TOGGLE: compare_output <= ~compare_output;
                    tmw_pkg::TMW_ACT_CLEAR: compare_output <= 1'b0;
                    tmw_pkg::TMW_ACT_SET: compare_output <= 1'b1;
                endcase
            end
        end else if (timer_tick) begin
            unique case (output_action_select)
                tmw_pkg::TMW_ACT_NONE: compare_output <= compare_output;
                tmw_pkg::TMW_ACT_TOGGLE: begin
                    if (match_now) begin
                        compare_output <= ~compare_output;
                    end
                end
                // Bottom wins over match so MAX gives a steady level
                tmw_pkg::TMW_ACT_CLEAR: begin
                    if (at_max) begin
                        compare_output <= 1'b1;
                    end else if (match_now) begin
                        compare_output <= 1'b0;
                    end
                end
                tmw_pkg::TMW_ACT_SET: begin
                    if (at_max) begin
                        compare_output <= 1'b0;
                    end else if (match_now) begin
                        compare_output <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Registered copy of the state for the system; software reads the state flip-flop itself
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            COMPARE_OUT <= 1'b0;
        end else begin
            COMPARE_OUT <= compare_output;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin override

    // Override follows output action only
    tmw_pin_mux u_pin_mux (
        .clk(CLK),
        .rstn(RSTN),
        .override(output_action_select != 2'h0),
        .compare_output(compare_output),
        .port_latch(PORT_LATCH),
        .pin_direction(PIN_DIRECTION),
        .pin_out(PIN_OUT),
        .pin_oe(PIN_OE)
    );

endmodule

/* tmw_timer_sva.sv */
// Port checker of the waveform timer
`timescale 1ns/10ps
`include "tmw_consts.svh"

module tmw_timer_sva (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Timer and flags
    input wire logic TICK,
    input wire logic MATCH_ACK,
    input wire logic WRAP_FLAG,
    input wire logic MATCH_FLAG,
    // Pin
    input wire logic PORT_LATCH,
    input wire logic PIN_DIRECTION,
    input wire logic PIN_OUT,
    input wire logic PIN_OE,
    input wire logic COMPARE_OUT
);
    logic [1:0] act;
    logic [1:0] wave;
    logic [2:0] src;
    logic [1:0] up;
    wire wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && !PSLVERR;
    wire wc = wr && PADDR == `TMW_OFS_CTRL;
    wire w1m = wr && PADDR == `TMW_OFS_FLAGS && PWDATA[`TMW_FLAG_MATCH];
    wire ftog = wc && PWDATA[0] && PWDATA[4:3] == 2'h1 && act == 2'h1 && !PWDATA[1]
        && !wave[0] && PWDATA[7:5] == 3'h0 && src == 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the control fields
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            act <= 2'h0;
            wave <= 2'h0;
            src <= 3'h0;
        end else if (wc) begin
            act <= PWDATA[4:3];
            wave <= PWDATA[2:1];
            src <= PWDATA[7:5];
        end
    end

    // Cycles since reset, saturating
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    ////////////////////////////////////////////////////////////////////////////
    property p_latch;
        up == 2'h3 && $past(act) == 2'h0 |-> PIN_OUT == $past(PORT_LATCH);
    endproperty
    a_latch: assert property (p_latch) else $error("pin not from port latch");
    property p_ovr;
        up == 2'h3 && $past(act) != 2'h0 |-> PIN_OUT == COMPARE_OUT;
    endproperty
    a_ovr: assert property (p_ovr) else $error("pin not from compare state");
    property p_oe;
        up == 2'h3 |-> PIN_OE == $past(PIN_DIRECTION);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable not from direction");
    property p_mfall;
        $fell(MATCH_FLAG) |-> $past(MATCH_ACK) || $past(w1m);
    endproperty
    a_mfall: assert property (p_mfall) else $error("match flag cleared alone");
    property p_mrise;
        $rose(MATCH_FLAG) |-> $past(TICK) && $past(src) != 3'h0;
    endproperty
    a_mrise: assert property (p_mrise) else $error("match flag set without tick");
    property p_wrise;
        $rose(WRAP_FLAG) |-> $past(TICK) && $past(src) != 3'h0;
    endproperty
    a_wrise: assert property (p_wrise) else $error("wrap flag set while stopped");
    property p_force;
        ftog |-> ##2 COMPARE_OUT != $past(COMPARE_OUT);
    endproperty
    a_force: assert property (p_force) else $error("force strobe did not toggle");
    property p_hold;
        up == 2'h3 && $past(act, 2) == 2'h0 |-> $stable(COMPARE_OUT);
    endproperty
    a_hold: assert property (p_hold) else $error("compare state moved with no action");
endmodule

/* tmw_pin_model.sv */
// Port pin seen from outside the timer
`timescale 1ns/10ps

module tmw_pin_model (
    // Clock
    input wire logic clk,
    // Pin drive
    input wire logic pin_out,
    input wire logic pin_oe,
    // Pin level
    output logic pin_level
);
    logic last_level = 1'b0;

    // Remember the last level the timer drove
    always_ff @(posedge clk) begin
        if (pin_oe) begin
            last_level <= pin_out;
        end
    end
    // Released pin shows the inverse, so a stale read cannot pass
    assign pin_level = pin_oe ? pin_out : !last_level;
endmodule

/* tmw_timer_bench.sv */
// Self-checking bench of the waveform timer
`timescale 1ns/10ps
`include "tmw_consts.svh"

module tmw_timer_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic tick = 1'b0;
    logic wack = 1'b0;
    logic mack = 1'b0;
    logic latch = 1'b0;
    logic dir = 1'b0;
    logic err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic [3:0] pstrb = 4'hF;
    wire [31:0] prdata;
    wire pready, pslverr, wflag, mflag, pout, poe, cout, lvl;
    int fail_count = 0;
    int total_checks = 0;

    initial forever #2 clk = ~clk;

    tmw_timer dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TICK(tick), .WRAP_ACK(wack), .MATCH_ACK(mack),
        .WRAP_FLAG(wflag), .MATCH_FLAG(mflag), .PORT_LATCH(latch), .PIN_DIRECTION(dir),
        .PIN_OUT(pout), .PIN_OE(poe), .COMPARE_OUT(cout));
    tmw_pin_model pin (.clk(clk), .pin_out(pout), .pin_oe(poe), .pin_level(lvl));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk) pen <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd[7:0]);
    endtask
    task ctl(input logic [1:0] wv, input logic [1:0] ac, input logic [2:0] s, input logic f);
        apb(1'b1, `TMW_OFS_CTRL, {24'h0, s, ac, wv, f});
    endtask
    task run(input int n);
        @(posedge clk) tick <= 1'b1;
        repeat (n) @(posedge clk);
        tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_regs;
        for (int i = 0; i < 4; i++) rdchk("reset", 8'(i * 4), 8'h00);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 8'h01, err);
        pstrb <= 4'hE;
        apb(1'b1, `TMW_OFS_COUNT, 32'h5A);
        pstrb <= 4'hF;
        rdchk("strobe", `TMW_OFS_COUNT, 8'h00);
        apb(1'b1, `TMW_OFS_COUNT, 32'h77);
        run(5);
        rdchk("stopped", `TMW_OFS_COUNT, 8'h77);
    endtask
    task t_normal;
        ctl(2'h0, 2'h0, 3'h1, 1'b0);
        apb(1'b1, `TMW_OFS_COUNT, 32'hFE);
        run(1);
        rdchk("count", `TMW_OFS_COUNT, `TMW_MAX);
        chk("wrap", 8'h00, wflag);
        run(1);
        chk("wrap", 8'h01, wflag);
        rdchk("count", `TMW_OFS_COUNT, `TMW_BOTTOM);
        @(posedge clk) wack <= 1'b1;
        @(posedge clk) wack <= 1'b0;
        @(posedge clk);
        chk("wrap", 8'h00, wflag);
    endtask
    task t_ctc;
        logic oc;
        ctl(2'h2, 2'h1, 3'h1, 1'b0);
        apb(1'b1, `TMW_OFS_COMPARE, 32'h3);
        apb(1'b1, `TMW_OFS_COUNT, 32'h0);
        oc = cout;
        run(3);
        chk("match", 8'h00, mflag);
        run(1);
        rdchk("count", `TMW_OFS_COUNT, 8'h00);
        chk("match", 8'h01, mflag);
        chk("cout", !oc, cout);
        apb(1'b1, `TMW_OFS_FLAGS, 32'h2);
        @(posedge clk);
        chk("match", 8'h00, mflag);
        apb(1'b1, `TMW_OFS_COUNT, 32'h3);
        run(1);
        rdchk("count", `TMW_OFS_COUNT, 8'h04);
        chk("match", 8'h00, mflag);
        apb(1'b1, `TMW_OFS_COUNT, 32'h5);
        run(250);
        rdchk("count", `TMW_OFS_COUNT, `TMW_MAX);
        chk("wrap", 8'h00, wflag);
        run(1);
        chk("wrap", 8'h01, wflag);
        apb(1'b1, `TMW_OFS_FLAGS, 32'h3);
    endtask
    task t_force;
        logic [1:0] acts[3] = '{2'h3, 2'h2, 2'h1};
        logic [0:0] outs[3] = '{1'b1, 1'b0, 1'b1};
        dir <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            ctl(2'h0, acts[i], 3'h0, 1'b0);
            ctl(2'h0, acts[i], 3'h0, 1'b1);
            repeat (2) @(posedge clk);
            chk("cout", outs[i], cout);
            chk("oe", 8'h00, poe);
            rdchk("ctrl", `TMW_OFS_CTRL, {3'h0, acts[i], 3'h0});
            rdchk("state", `TMW_OFS_FLAGS, {5'h0, outs[i], 2'h0});
        end
        chk("match", 8'h00, mflag);
        dir <= 1'b1;
        repeat (3) @(posedge clk);
        chk("pin", 8'h01, lvl);
        ctl(2'h0, 2'h0, 3'h0, 1'b0);
        latch <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pin", 8'h00, lvl);
        latch <= 1'b1;
        repeat (3) @(posedge clk);
        chk("pin", 8'h01, lvl);
    endtask
    task t_pwm;
        for (logic [1:0] ac = 2'h2; ac != 2'h0; ac++) begin
            ctl({ac[0], 1'b1}, ac, 3'h1, 1'b0);
            apb(1'b1, `TMW_OFS_COMPARE, 32'h10);
            apb(1'b1, `TMW_OFS_COUNT, 32'hFE);
            apb(1'b1, `TMW_OFS_FLAGS, 32'h3);
            run(1);
            chk("wrap", 8'h01, wflag);
            run(1);
            rdchk("count", `TMW_OFS_COUNT, `TMW_BOTTOM);
            chk("cout", ac == 2'h2, cout);
            apb(1'b1, `TMW_OFS_COMPARE, 32'h30);
            rdchk("buffer", `TMW_OFS_COMPARE, 8'h30);
            run(16);
            chk("cout", ac == 2'h2, cout);
            run(1);
            chk("cout", ac == 2'h3, cout);
            chk("pin", cout, lvl);
            chk("match", 8'h01, mflag);
            @(posedge clk) mack <= 1'b1;
            @(posedge clk) mack <= 1'b0;
            @(posedge clk);
            chk("match", 8'h00, mflag);
        end
        ctl(2'h0, 2'h0, 3'h0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_normal();
        t_ctc();
        t_force();
        t_pwm();
        tally_and_finish();
    end
    initial begin
        #80000;
        fail_count++;
        tally_and_finish();
    end
endmodule

bind tmw_timer tmw_timer_sva u_sva (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PSTRB, .PREADY, .PSLVERR, .TICK, .MATCH_ACK, .WRAP_FLAG, .MATCH_FLAG, .PORT_LATCH,
    .PIN_DIRECTION, .PIN_OUT, .PIN_OE, .COMPARE_OUT);
